// ===== rtl/scc_map.vh
// Constants for the synthesizer channel and calibration controller
// Behaviour
// RQ1 - Tune to five-bit channel, 0x0B..0x1A
// RQ2 - Off to synth-on settles 110us, then lock
// RQ3 - Channel change in synth/receive within 11us
// RQ4 - Retune 16us before sending, 32us after
// RQ5 - Transmit retunes raise neither lock nor unlock
// RQ6 - Synth enable starts centre and delay calibrations
// RQ7 - New channel frequency starts centre tuning
// RQ8 - Software recalibrates after 5 min or temperature
// RQ9 - Software calibrates only in synth/receive states
// RQ10 - Centre tuning end raises lock interrupt; code raises it only after start-bit tuning
// RQ11 - Centre and delay calibrations may run together
// RQ12 - Unlock on lock loss; each clears other
// RQ13 - Lock on off-to-active and active channel change
// RQ14 - Busy-transmit to synth-on raises no lock
// RQ15 - Centre start bit runs 35us, self-clears
// RQ16 - Delay start bit runs 6us, self-clears
// RQ17 - Filter tuning starts on entering off state; code starts it only from sleep, reset or power-on
// RQ18 - Software filter-tunes only in off/synth/receive
// RQ19 - Software repeats filter tuning within 5 min
// RQ20 - Filter start bit runs 25us, self-clears
// RQ21 - Start bit reads one while cycle runs
`ifndef SCC_MAP_VH
`define SCC_MAP_VH

`define SCC_CLK_MHZ       10
`define SCC_T_ENABLE_US   110
`define SCC_T_CHAN_US     11
`define SCC_T_TXTUNE_US   16
`define SCC_T_RXTUNE_US   32
`define SCC_T_CF_US       35
`define SCC_T_DCU_US      6
`define SCC_T_FTN_US      25
// Cycle counts at the reference clock, microseconds times ten
`define SCC_CYC_ENABLE    11'h44c
`define SCC_CYC_CHAN      11'h06e
`define SCC_CYC_TXTUNE    11'h0a0
`define SCC_CYC_RXTUNE    11'h140
`define SCC_CYC_CF        11'h15e
`define SCC_CYC_DCU       11'h03c
`define SCC_CYC_FTN       11'h0fa

// Register indices; byte address is four times the index
`define SCC_IDX_CHAN      8'h08
`define SCC_IDX_FTN       8'h18
`define SCC_IDX_CF        8'h1a
`define SCC_IDX_DCU       8'h1b
`define SCC_IDX_STAT      8'h1c

`define SCC_RST_CHAN      5'h0b
`define SCC_RST_FTN       7'h58
`define SCC_RST_CF        7'h57
`define SCC_RST_DCU       6'h20
`define SCC_GO_BIT        7
`define SCC_CHAN_MIN      5'h0b
`define SCC_CHAN_MAX      5'h1a
`define SCC_FREQ_BASE     12'h965
`define SCC_FREQ_STEP     12'h005
`define SCC_DCU_RO_BIT    6

`define SCC_RESP_OKAY     2'h0
`define SCC_RESP_SLVERR   2'h2

// Transceiver state codes
`define SCC_ST_PON        5'h00
`define SCC_ST_BUSYTX     5'h02
`define SCC_ST_RX         5'h06
`define SCC_ST_OFF        5'h08
`define SCC_ST_SYN        5'h09
`define SCC_ST_RESET      5'h0e
`define SCC_ST_SLEEP      5'h0f
`define SCC_ST_AACK       5'h16
`define SCC_ST_EXT        5'h19

`endif

// ===== rtl/scc_cal_timer.v
// Loadable one-shot cycle timer with busy level and done pulse
`timescale 1ns/1ps
`include "scc_map.vh"
module scc_cal_timer (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        sys_rst,
    // Control
    input  wire        start,
    input  wire [10:0] len,
    // Status
    output reg         busy_q,
    output reg         done_q
);
    reg [10:0] cnt_q;

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q  <= 11'h000;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start) begin
                cnt_q  <= len;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 11'h001;
                if (cnt_q == 11'h001) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end
endmodule // scc_cal_timer

// ===== rtl/scc_synth_cal_ctrl.v
// Synthesizer channel, retune timing, calibration starts and lock events
`timescale 1ns/1ps
`include "scc_map.vh"
module scc_synth_cal_ctrl (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        sys_rst,
    // AXI4-Lite write address
    input  wire [9:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read
    input  wire [9:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Transceiver state machine
    input  wire [4:0]  trxState,
    input  wire        txStart,
    input  wire        txDone,
    // Analog loop
    input  wire        pllLockRaw,
    output reg  [4:0]  channel_q,
    output reg  [11:0] centreFreqMhz_q,
    output reg         txFreqSel_q,
    output reg         txSendGo_q,
    output wire        centreTuneRun,
    output wire        delayCellRun,
    output wire        filterTuneRun,
    // Events
    output reg         lockIrq_q,
    output reg         unlockIrq_q
);
    ////////////////////////////////////////////////////////////////////////////
    function isActive;
        input [4:0] st;
        begin
            isActive = (st == `SCC_ST_SYN) || (st == `SCC_ST_RX) ||
                       (st == `SCC_ST_EXT) || (st == `SCC_ST_AACK);
        end
    endfunction

    function [11:0] chanFreq;
        input [4:0] k;
        begin
            chanFreq = `SCC_FREQ_BASE + ({7'h00, k - `SCC_CHAN_MIN} * `SCC_FREQ_STEP);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    reg  [6:0]  ftnRsv_q;
    reg  [6:0]  cfRsv_q;
    reg  [5:0]  dcuRsv_q;
    reg         lockPend_q;
    reg         unlockPend_q;
    reg         cfManual_q;
    reg  [4:0]  prevState_q;
    reg         lockS1_q;
    reg         lockS2_q;
    reg         lockS3_q;
    reg         lockStable_q;
    reg         lockStablePrev_q;

    // Bus capture
    reg  [7:0]  awIdx_q;
    reg         awHave_q;
    reg  [7:0]  wByte_q;
    reg         wLane0_q;
    reg         wHave_q;

    wire        doWrite = awHave_q && wHave_q && !s_axi_bvalid;
    wire        wrLane  = doWrite && wLane0_q;
    wire        wrChan  = wrLane && (awIdx_q == `SCC_IDX_CHAN);
    wire        wrFtn   = wrLane && (awIdx_q == `SCC_IDX_FTN);
    wire        wrCf    = wrLane && (awIdx_q == `SCC_IDX_CF);
    wire        wrDcu   = wrLane && (awIdx_q == `SCC_IDX_DCU);
    wire        wrStat  = wrLane && (awIdx_q == `SCC_IDX_STAT);
    wire        goBit   = wByte_q[`SCC_GO_BIT];
    wire        wrHit   = (awIdx_q == `SCC_IDX_CHAN) || (awIdx_q == `SCC_IDX_FTN) ||
                          (awIdx_q == `SCC_IDX_CF) || (awIdx_q == `SCC_IDX_DCU) ||
                          (awIdx_q == `SCC_IDX_STAT);

    ////////////////////////////////////////////////////////////////////////////
    // Event decode
    wire        stChanged  = (prevState_q != trxState);
    wire        enableEvt  = stChanged && (prevState_q == `SCC_ST_OFF) &&
                             isActive(trxState);
    wire        offEntry   = stChanged && (trxState == `SCC_ST_OFF) &&
                             ((prevState_q == `SCC_ST_SLEEP) ||
                              (prevState_q == `SCC_ST_RESET) ||
                              (prevState_q == `SCC_ST_PON));
    wire [4:0]  newChan    = wByte_q[4:0];
    wire        chanEvt    = wrChan && (newChan != channel_q) && isActive(trxState);
    wire        txGoEvt    = txStart && ((trxState == `SCC_ST_SYN) ||
                                         (trxState == `SCC_ST_EXT));

    wire        settleBusy;
    wire        settleDone;
    wire        retuneBusy;
    wire        retuneDone;
    wire        cfDone;

    wire        cfStart    = enableEvt || chanEvt || (wrCf && goBit);  // RQ6 RQ7 RQ15
    wire        dcuStart   = enableEvt || (wrDcu && goBit);  // RQ6 RQ16 RQ11
    wire        ftnStart   = offEntry || (wrFtn && goBit);  // RQ17 RQ20
    wire        settleGo   = enableEvt || chanEvt;  // RQ2 RQ3
    wire [10:0] settleLen  = enableEvt ? `SCC_CYC_ENABLE  // RQ2
                                       : `SCC_CYC_CHAN;  // RQ3
    wire        retuneGo   = txGoEvt || txDone;  // RQ4
    wire [10:0] retuneLen  = txGoEvt ? `SCC_CYC_TXTUNE
                                     : `SCC_CYC_RXTUNE;  // RQ4

    // Lock takes precedence; transmit retunes emit nothing
    wire        lockEvt    = settleDone || (cfDone && cfManual_q);  // RQ13 RQ10 RQ14
    wire        lockFall   = lockStablePrev_q && !lockStable_q;
    wire        unlockEvt  = lockFall && isActive(trxState) && !settleBusy &&
                             !retuneBusy && !centreTuneRun && !delayCellRun;  // RQ12 RQ5

    ////////////////////////////////////////////////////////////////////////////
    // Timers
    scc_cal_timer uCfTimer (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .start   (cfStart),
        .len     (`SCC_CYC_CF),
        .busy_q  (centreTuneRun),
        .done_q  (cfDone)
    );

    scc_cal_timer uDcuTimer (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .start   (dcuStart),
        .len     (`SCC_CYC_DCU),
        .busy_q  (delayCellRun),
        .done_q  ()
    );

    scc_cal_timer uFtnTimer (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .start   (ftnStart),
        .len     (`SCC_CYC_FTN),
        .busy_q  (filterTuneRun),
        .done_q  ()
    );

    scc_cal_timer uSettleTimer (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .start   (settleGo),
        .len     (settleLen),
        .busy_q  (settleBusy),
        .done_q  (settleDone)
    );

    scc_cal_timer uRetuneTimer (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .start   (retuneGo),
        .len     (retuneLen),
        .busy_q  (retuneBusy),
        .done_q  (retuneDone)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Lock indicator synchroniser, change accepted when stages two and three agree
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lockS1_q         <= 1'b0;
            lockS2_q         <= 1'b0;
            lockS3_q         <= 1'b0;
            lockStable_q     <= 1'b0;
            lockStablePrev_q <= 1'b0;
        end else begin
            lockS1_q         <= pllLockRaw;
            lockS2_q         <= lockS1_q;
            lockS3_q         <= lockS2_q;
            lockStablePrev_q <= lockStable_q;
            if (lockS2_q == lockS3_q) begin
                lockStable_q <= lockS3_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel, retune and events
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prevState_q     <= `SCC_ST_PON;
            channel_q       <= `SCC_RST_CHAN;
            centreFreqMhz_q <= `SCC_FREQ_BASE;
            txFreqSel_q     <= 1'b0;
            txSendGo_q      <= 1'b0;
            lockIrq_q       <= 1'b0;
            unlockIrq_q     <= 1'b0;
            lockPend_q      <= 1'b0;
            unlockPend_q    <= 1'b0;
            cfManual_q      <= 1'b0;
        end else begin
            prevState_q <= trxState;
            if (wrChan) begin
                channel_q <= newChan;
                if ((newChan >= `SCC_CHAN_MIN) && (newChan <= `SCC_CHAN_MAX)) begin
                    centreFreqMhz_q <= chanFreq(newChan);  // RQ1
                end
            end
            if (txGoEvt) begin
                txFreqSel_q <= 1'b1;  // RQ4
            end else if (txDone) begin
                txFreqSel_q <= 1'b0;  // RQ4
            end
            txSendGo_q <= retuneDone && txFreqSel_q;  // RQ4
            if (cfStart) begin
                cfManual_q <= wrCf && goBit && !enableEvt && !chanEvt;  // RQ10
            end
            lockIrq_q   <= lockEvt;
            unlockIrq_q <= unlockEvt && !lockEvt;
            if (lockEvt) begin
                lockPend_q   <= 1'b1;  // RQ12
                unlockPend_q <= 1'b0;  // RQ12
            end else if (unlockEvt) begin
                unlockPend_q <= 1'b1;  // RQ12
                lockPend_q   <= 1'b0;  // RQ12
            end else if (wrStat) begin
                lockPend_q   <= lockPend_q & ~wByte_q[0];
                unlockPend_q <= unlockPend_q & ~wByte_q[1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register write side
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ftnRsv_q <= `SCC_RST_FTN;
            cfRsv_q  <= `SCC_RST_CF;
            dcuRsv_q <= `SCC_RST_DCU;
        end else begin
            if (wrFtn) begin
                ftnRsv_q <= wByte_q[6:0];
            end
            if (wrCf) begin
                cfRsv_q <= wByte_q[6:0];
            end
            if (wrDcu) begin
                dcuRsv_q <= wByte_q[5:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channels
    wire awHave_d = awHave_q ? !doWrite : (s_axi_awvalid && s_axi_awready);
    wire wHave_d  = wHave_q ? !doWrite : (s_axi_wvalid && s_axi_wready);

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            awIdx_q       <= 8'h00;
            awHave_q      <= 1'b0;
            wByte_q       <= 8'h00;
            wLane0_q      <= 1'b0;
            wHave_q       <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SCC_RESP_OKAY;
        end else begin
            awHave_q      <= awHave_d;
            wHave_q       <= wHave_d;
            s_axi_awready <= !awHave_d;
            s_axi_wready  <= !wHave_d;
            if (s_axi_awvalid && s_axi_awready) begin
                awIdx_q <= s_axi_awaddr[9:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wByte_q  <= s_axi_wdata[7:0];
                wLane0_q <= s_axi_wstrb[0];
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrHit ? `SCC_RESP_OKAY : `SCC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel
    reg  [7:0] rdByte;
    reg        rdHit;
    wire [7:0] arIdx = s_axi_araddr[9:2];

    always @* begin
        rdHit  = 1'b1;
        rdByte = 8'h00;
        case (arIdx)
            `SCC_IDX_CHAN: rdByte = {3'h0, channel_q};
            `SCC_IDX_FTN:  rdByte = {filterTuneRun, ftnRsv_q};  // RQ21
            `SCC_IDX_CF:   rdByte = {centreTuneRun, cfRsv_q};  // RQ21
            `SCC_IDX_DCU:  rdByte = {delayCellRun, 1'b0, dcuRsv_q};  // RQ21
            `SCC_IDX_STAT: rdByte = {2'h0, settleBusy, retuneBusy, txFreqSel_q,
                                     lockStable_q, unlockPend_q, lockPend_q};
            default:       rdHit  = 1'b0;
        endcase
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `SCC_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {24'h000000, rdByte};
                s_axi_rresp   <= rdHit ? `SCC_RESP_OKAY : `SCC_RESP_SLVERR;
            end else if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid  <= 1'b0;
                    s_axi_arready <= 1'b1;
                end
            end else begin
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // scc_synth_cal_ctrl

// ===== test/scc_synth_cal_ctrl_asserts.sv
// Checker for the synthesizer channel and calibration controller
`timescale 1ns/1ps
`include "scc_map.vh"
module scc_synth_cal_ctrl_asserts (
    // Clock and reset
    input wire        ref_clk,
    input wire        sys_rst,
    // Transceiver state
    input wire [4:0]  trxState,
    // Loop control and events
    input wire [4:0]  channel_q,
    input wire [11:0] centreFreqMhz_q,
    input wire        txFreqSel_q,
    input wire        txSendGo_q,
    input wire        centreTuneRun,
    input wire        delayCellRun,
    input wire        filterTuneRun,
    input wire        lockIrq_q,
    input wire        unlockIrq_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////////
    AST_CF_LEN: assert property ($rose(centreTuneRun) |-> ##[349:349] centreTuneRun ##1 !centreTuneRun)
        else $error("centre tuning length wrong");
    AST_DCU_LEN: assert property ($rose(delayCellRun) |-> ##59 delayCellRun ##1 !delayCellRun)
        else $error("delay cell calibration length wrong");
    AST_FTN_LEN: assert property ($rose(filterTuneRun) |-> ##249 filterTuneRun ##1 !filterTuneRun)
        else $error("filter tuning length wrong");
    AST_TX_GO: assert property ($rose(txFreqSel_q) |-> ##[155:165] txSendGo_q)
        else $error("transmit retune not done in time");
    AST_GO_PULSE: assert property (txSendGo_q |=> !txSendGo_q)
        else $error("send go longer than one cycle");
    AST_TX_QUIET: assert property (txFreqSel_q |-> !lockIrq_q && !unlockIrq_q)
        else $error("event during transmit retune");
    AST_RET_QUIET: assert property ($fell(txFreqSel_q) |-> (!lockIrq_q && !unlockIrq_q) [*8])
        else $error("event during return retune");
    AST_IRQ_EXCL: assert property (lockIrq_q |-> !unlockIrq_q)
        else $error("lock and unlock together");
    AST_AUTO_CAL: assert property (($past(trxState) == `SCC_ST_OFF && trxState == `SCC_ST_SYN)
        |-> ##[1:3] (centreTuneRun && delayCellRun))
        else $error("calibrations not started on enable");
    AST_FTN_AUTO: assert property (($past(trxState) == `SCC_ST_SLEEP && trxState == `SCC_ST_OFF)
        |-> ##[1:3] filterTuneRun)
        else $error("filter tuning not started on wake");
    AST_FREQ: assert property ((channel_q >= `SCC_CHAN_MIN && channel_q <= `SCC_CHAN_MAX)
        ##1 $stable(channel_q) |-> centreFreqMhz_q == 12'h92e + 12'h005 * {7'h00, channel_q})
        else $error("centre frequency wrong for channel");
    COV_LOCK: cover property (lockIrq_q);
    COV_UNLOCK: cover property (unlockIrq_q);
    COV_SEND: cover property (txSendGo_q);
endmodule // scc_synth_cal_ctrl_asserts

bind scc_synth_cal_ctrl scc_synth_cal_ctrl_asserts i_scc_synth_cal_ctrl_asserts (
    .ref_clk, .sys_rst, .trxState, .channel_q, .centreFreqMhz_q, .txFreqSel_q, .txSendGo_q,
    .centreTuneRun, .delayCellRun, .filterTuneRun, .lockIrq_q, .unlockIrq_q);

// ===== test/scc_synth_cal_ctrl_tb_top.sv
// Self-checking bench for the synthesizer channel and calibration controller
`timescale 1ns/1ps
`include "scc_map.vh"
module scc_synth_cal_ctrl_tb_top;
    logic        ref_clk = 1'h0;
    logic        sys_rst = 1'h1;
    logic [9:0]  s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h1;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [4:0]  trxState = `SCC_ST_OFF, channel_q;
    logic        txStart = 1'h0, txDone = 1'h0, pllLockRaw = 1'h1;
    logic [11:0] centreFreqMhz_q;
    logic        txFreqSel_q, txSendGo_q, centreTuneRun, delayCellRun, filterTuneRun;
    logic        lockIrq_q, unlockIrq_q;
    int          miscompares = 0, checks = 0, n, k, kk;

    always #50 ref_clk = ~ref_clk;

    scc_synth_cal_ctrl i_scc_synth_cal_ctrl (
        .ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .trxState, .txStart, .txDone, .pllLockRaw, .channel_q,
        .centreFreqMhz_q, .txFreqSel_q, .txSendGo_q, .centreTuneRun, .delayCellRun,
        .filterTuneRun, .lockIrq_q, .unlockIrq_q);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic a, w;
        a = 1'h0;
        w = 1'h0;
        @(posedge ref_clk);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready === 1'h1 && !a) begin
                a = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (s_axi_wready === 1'h1 && !w) begin
                w = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end while (s_axi_bvalid !== 1'h1);
        chk("bresp", s_axi_bresp, er);
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
        @(posedge ref_clk);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready === 1'h1)
                s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        chk("rdata", s_axi_rdata, exp);
        chk("rresp", s_axi_rresp, er);
        s_axi_rready <= 1'h0;
    endtask

    // Counts edges until a lock event is sampled
    task automatic waitLock(output int c);
        c = 0;
        do begin
            @(posedge ref_clk);
            c++;
        end while (lockIrq_q !== 1'h1 && c < 3000);
    endtask

    task automatic end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        end_of_test;
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'h0;
        repeat (3) @(posedge ref_clk);
        #1 chk("ftnAfterReset", filterTuneRun, 1'h1);
        rd(`SCC_IDX_FTN, 32'hd8, `SCC_RESP_OKAY);
        rd(`SCC_IDX_CHAN, 32'h0b, `SCC_RESP_OKAY);
        rd(`SCC_IDX_CF, 32'h57, `SCC_RESP_OKAY);
        rd(`SCC_IDX_DCU, 32'h20, `SCC_RESP_OKAY);
        rd(8'h30, 32'h0, `SCC_RESP_SLVERR);
        wr(8'h30, 8'hff, `SCC_RESP_SLVERR);
        wr(`SCC_IDX_DCU, 8'h7f, `SCC_RESP_OKAY);
        rd(`SCC_IDX_DCU, 32'h3f, `SCC_RESP_OKAY);
        repeat (260) @(posedge ref_clk);
        rd(`SCC_IDX_FTN, 32'h58, `SCC_RESP_OKAY);
        $display("test reset and registers done");
        @(posedge ref_clk);
        trxState <= `SCC_ST_SYN;
        repeat (3) @(posedge ref_clk);
        #1 chk("autoCal", {centreTuneRun, delayCellRun}, 2'h3);
        waitLock(n);
        chk("enableSettle", n >= 1090 && n <= 1110, 1'h1);
        $display("test synthesizer enable done");
        for (k = 12; k <= 27; k++) begin
            kk = (k == 27) ? 11 : k;
            wr(`SCC_IDX_CHAN, 8'(kk), `SCC_RESP_OKAY);
            #1 chk("chanCal", centreTuneRun, 1'h1);
            waitLock(n);
            chk("chanSettle", n <= 120, 1'h1);
            chk("freq", centreFreqMhz_q, `SCC_FREQ_BASE + `SCC_FREQ_STEP * 12'(kk - 11));
            // Let centre tuning end so the next change starts a fresh cycle
            repeat (250) @(posedge ref_clk);
        end
        $display("test channel sweep done");
        wr(`SCC_IDX_CF, 8'hd7, `SCC_RESP_OKAY);
        wr(`SCC_IDX_DCU, 8'ha0, `SCC_RESP_OKAY);
        #1 chk("bothRun", {centreTuneRun, delayCellRun}, 2'h3);
        rd(`SCC_IDX_CF, 32'hd7, `SCC_RESP_OKAY);
        rd(`SCC_IDX_DCU, 32'ha0, `SCC_RESP_OKAY);
        waitLock(n);
        chk("cfEnd", n >= 300 && n <= 350, 1'h1);
        rd(`SCC_IDX_CF, 32'h57, `SCC_RESP_OKAY);
        rd(`SCC_IDX_DCU, 32'h20, `SCC_RESP_OKAY);
        $display("test manual calibration done");
        @(posedge ref_clk);
        txStart <= 1'h1;
        @(posedge ref_clk);
        txStart <= 1'h0;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (txSendGo_q !== 1'h1 && n < 400);
        chk("txTune", n >= 158 && n <= 162, 1'h1);
        trxState <= `SCC_ST_BUSYTX;
        repeat (20) @(posedge ref_clk);
        txDone <= 1'h1;
        trxState <= `SCC_ST_SYN;
        @(posedge ref_clk);
        txDone <= 1'h0;
        n = 0;
        repeat (340) begin
            @(posedge ref_clk);
            if (lockIrq_q === 1'h1 || unlockIrq_q === 1'h1)
                n++;
        end
        chk("retuneQuiet", n, 32'h0);
        $display("test transmit retune done");
        pllLockRaw <= 1'h0;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (unlockIrq_q !== 1'h1 && n < 20);
        chk("unlockIrq", n <= 8, 1'h1);
        rd(`SCC_IDX_STAT, 32'h02, `SCC_RESP_OKAY);
        pllLockRaw <= 1'h1;
        wr(`SCC_IDX_CF, 8'hd7, `SCC_RESP_OKAY);
        waitLock(n);
        rd(`SCC_IDX_STAT, 32'h05, `SCC_RESP_OKAY);
        wr(`SCC_IDX_STAT, 8'h01, `SCC_RESP_OKAY);
        rd(`SCC_IDX_STAT, 32'h04, `SCC_RESP_OKAY);
        $display("test lock events done");
        wr(`SCC_IDX_FTN, 8'hd8, `SCC_RESP_OKAY);
        rd(`SCC_IDX_FTN, 32'hd8, `SCC_RESP_OKAY);
        repeat (260) @(posedge ref_clk);
        rd(`SCC_IDX_FTN, 32'h58, `SCC_RESP_OKAY);
        for (k = 0; k < 2; k++) begin
            @(posedge ref_clk);
            trxState <= (k == 0) ? `SCC_ST_SLEEP : `SCC_ST_RESET;
            @(posedge ref_clk);
            trxState <= `SCC_ST_OFF;
            repeat (3) @(posedge ref_clk);
            #1 chk("ftnAuto", filterTuneRun, 1'h1);
            repeat (260) @(posedge ref_clk);
        end
        $display("test filter tuning done");
        end_of_test;
    end
endmodule // scc_synth_cal_ctrl_tb_top
